// File: hdl/pchcm_consts.svh
`ifndef PCHCM_CONSTS_SVH
`define PCHCM_CONSTS_SVH

// register byte offsets
`define PCHCM_OFS_MODE 4'h0
`define PCHCM_OFS_FACTORS 4'h4
`define PCHCM_OFS_CTRL 4'h8
`define PCHCM_OFS_RATIO 4'hc

// hard reset word field holding the upper mode nibble
`define PCHCM_RSTWORD_NIBBLE_LSB 28
`define PCHCM_RSTWORD_NIBBLE_MSB 31

// control register layout and reset value
`define PCHCM_CTRL_DIV_LSB 0
`define PCHCM_CTRL_DIV_MSB 3
`define PCHCM_CTRL_RESET 4'h3

// mode register layout
`define PCHCM_MODE_CODE_LSB 0
`define PCHCM_MODE_CODE_MSB 6
`define PCHCM_MODE_RSVD_BIT 8
`define PCHCM_MODE_VALID_BIT 9
`define PCHCM_MODE_RANGE_BIT 10

// factors register layout, all factors in half steps
`define PCHCM_FAC_COMMS_LSB 0
`define PCHCM_FAC_CORE_LSB 8
`define PCHCM_FAC_PCI_LSB 16

// ratio register layout
`define PCHCM_RATIO_BAD_BIT 8

// fixed ratios for the lower pci range, in half steps
`define PCHCM_LOW_DF_3 4'h3
`define PCHCM_LOW_DF_5 4'h5
`define PCHCM_LOW_DF_7 4'h7
`define PCHCM_LOW_DF_9 4'h9
`define PCHCM_LOW_DF_B 4'hb
`define PCHCM_LOW_X2_3 5'h08
`define PCHCM_LOW_X2_5 5'h0c
`define PCHCM_LOW_X2_7 5'h10
`define PCHCM_LOW_X2_9 5'h0a
`define PCHCM_LOW_X2_B 5'h0c

`endif

// File: hdl/pchcm_pkg.sv
`default_nettype none
package pchcm_pkg;

  // factor in half steps: 5 means 2.5
  typedef logic [4:0] pchcm_half_t;

  typedef struct packed {
    logic reserved;
    pchcm_half_t comms_x2;
    pchcm_half_t core_x2;
    pchcm_half_t pci_div_x2;
  } pchcm_factors_t;

  typedef struct packed {
    logic ratio_bad;
    pchcm_half_t comms_pci_x2;
  } pchcm_ratio_t;

  typedef enum logic [0:0] {
    PCHCM_ST_WAIT = 1'b0,
    PCHCM_ST_LOCKED = 1'b1
  } pchcm_state_t;

endpackage
`default_nettype wire

// File: hdl/pchcm_mode_lut.sv
`include "pchcm_consts.svh"
`default_nettype none
module pchcm_mode_lut
  import pchcm_pkg::*;
(
  input wire logic [6:0] mode_code,
  output pchcm_factors_t factors
);

  function automatic pchcm_factors_t fac(input logic rsv, input logic [4:0] c,
                                         input logic [4:0] k, input logic [4:0] p);
    fac.reserved = rsv;
    fac.comms_x2 = c;
    fac.core_x2 = k;
    fac.pci_div_x2 = p;
  endfunction

  // modes absent from the table are flagged reserved with zero factors
  always_comb
  begin
    case (mode_code)
      7'h5c: factors = fac(1'b0, 5'h05, 5'h08, 5'h08);
      7'h5d: factors = fac(1'b0, 5'h05, 5'h09, 5'h08);
      7'h68: factors = fac(1'b0, 5'h05, 5'h06, 5'h0a);
      7'h69: factors = fac(1'b0, 5'h05, 5'h07, 5'h0a);
      7'h6a: factors = fac(1'b0, 5'h05, 5'h08, 5'h0a);
      7'h6b: factors = fac(1'b0, 5'h05, 5'h09, 5'h0a);
      7'h6c: factors = fac(1'b0, 5'h05, 5'h0a, 5'h0a);
      7'h6d: factors = fac(1'b0, 5'h04, 5'h06, 5'h0a);
      7'h6e: factors = fac(1'b0, 5'h04, 5'h08, 5'h0a);
      7'h70: factors = fac(1'b0, 5'h06, 5'h07, 5'h0c);
      7'h71: factors = fac(1'b0, 5'h06, 5'h08, 5'h0c);
      7'h72: factors = fac(1'b0, 5'h06, 5'h09, 5'h0c);
      7'h73: factors = fac(1'b0, 5'h06, 5'h0a, 5'h0c);
      7'h74: factors = fac(1'b0, 5'h06, 5'h0b, 5'h0c);
      default: factors = fac(1'b1, 5'h00, 5'h00, 5'h00);
    endcase
  end

endmodule
`default_nettype wire

// File: hdl/pchcm_top.sv
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`include "pchcm_consts.svh"
`default_nettype none
module pchcm_top
  import pchcm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] hard_reset_word,
  input wire logic [2:0] mode_code_config_pins,
  input wire logic pci_range_select,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic cfg_valid,
  output logic mode_reserved,
  output logic [4:0] comms_mult_x2,
  output logic [4:0] core_pll_mult_x2,
  output logic [4:0] pci_div_x2,
  output logic [4:0] comms_pci_ratio_x2,
  output logic comms_pci_ratio_bad
);

  pchcm_state_t state;
  pchcm_state_t next_state;
  logic [6:0] mode_code;
  logic [6:0] next_mode_code;
  logic range_sel;
  logic next_range_sel;
  logic [3:0] pci_divide_field;
  logic [3:0] next_pci_divide_field;
  pchcm_factors_t lut_factors;
  pchcm_factors_t factors;
  pchcm_factors_t next_factors;
  pchcm_ratio_t ratio;
  pchcm_ratio_t next_ratio;
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;

  // comms-to-pci ratio in half steps from range and divide field
  function automatic pchcm_ratio_t pci_ratio(input logic rng, input logic [3:0] df);
    pci_ratio.ratio_bad = 1'b0;
    pci_ratio.comms_pci_x2 = 5'h00;
    if (!rng)
    begin
      pci_ratio.comms_pci_x2 = {1'b0, df} + 5'h01;
    end
    else
    begin
      case (df)
        `PCHCM_LOW_DF_3: pci_ratio.comms_pci_x2 = `PCHCM_LOW_X2_3;
        `PCHCM_LOW_DF_5: pci_ratio.comms_pci_x2 = `PCHCM_LOW_X2_5;
        `PCHCM_LOW_DF_7: pci_ratio.comms_pci_x2 = `PCHCM_LOW_X2_7;
        `PCHCM_LOW_DF_9: pci_ratio.comms_pci_x2 = `PCHCM_LOW_X2_9;
        `PCHCM_LOW_DF_B: pci_ratio.comms_pci_x2 = `PCHCM_LOW_X2_B;
        default: pci_ratio.ratio_bad = 1'b1;
      endcase
    end
  endfunction

  pchcm_mode_lut u_lut (
    .mode_code(mode_code),
    .factors(lut_factors)
  );

  // mode straps caught once, on the first edge after reset release
  always_comb
  begin
    next_state = state;
    next_mode_code = mode_code;
    next_range_sel = range_sel;
    case (state)
      PCHCM_ST_WAIT:
      begin
        next_mode_code = {hard_reset_word[`PCHCM_RSTWORD_NIBBLE_MSB:`PCHCM_RSTWORD_NIBBLE_LSB],
                          mode_code_config_pins};
        next_range_sel = pci_range_select;
        next_state = PCHCM_ST_LOCKED;
      end
      PCHCM_ST_LOCKED:
      begin
        next_state = PCHCM_ST_LOCKED;
      end
      default:
      begin
        next_state = PCHCM_ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= PCHCM_ST_WAIT;
      mode_code <= 7'h00;
      range_sel <= 1'b0;
    end
    else
    begin
      state <= next_state;
      mode_code <= next_mode_code;
      range_sel <= next_range_sel;
    end
  end

  // factors stay zero until the straps are caught
  always_comb
  begin
    next_factors = '0;
    if (state == PCHCM_ST_LOCKED)
    begin
      next_factors = lut_factors;
    end
    next_ratio = pci_ratio(range_sel, pci_divide_field);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      factors <= '0;
      ratio <= '0;
    end
    else
    begin
      factors <= next_factors;
      ratio <= next_ratio;
    end
  end

  // one wait cycle per access keeps read data on a flop
  always_comb
  begin
    next_ack = 1'b0;
    next_readdata = avs_readdata;
    next_pci_divide_field = pci_divide_field;
    if ((avs_read || avs_write) && !ack)
    begin
      next_ack = 1'b1;
      if (avs_read)
      begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
          `PCHCM_OFS_MODE:
          begin
            next_readdata[`PCHCM_MODE_CODE_MSB:`PCHCM_MODE_CODE_LSB] = mode_code;
            next_readdata[`PCHCM_MODE_RSVD_BIT] = factors.reserved;
            next_readdata[`PCHCM_MODE_VALID_BIT] = (state == PCHCM_ST_LOCKED);
            next_readdata[`PCHCM_MODE_RANGE_BIT] = range_sel;
          end
          `PCHCM_OFS_FACTORS:
          begin
            next_readdata[`PCHCM_FAC_COMMS_LSB +: 5] = factors.comms_x2;
            next_readdata[`PCHCM_FAC_CORE_LSB +: 5] = factors.core_x2;
            next_readdata[`PCHCM_FAC_PCI_LSB +: 5] = factors.pci_div_x2;
          end
          `PCHCM_OFS_CTRL:
          begin
            next_readdata[`PCHCM_CTRL_DIV_MSB:`PCHCM_CTRL_DIV_LSB] = pci_divide_field;
          end
          `PCHCM_OFS_RATIO:
          begin
            next_readdata[4:0] = ratio.comms_pci_x2;
            next_readdata[`PCHCM_RATIO_BAD_BIT] = ratio.ratio_bad;
          end
          default:
          begin
            next_readdata = 32'h0000_0000;
          end
        endcase
      end
      else if (avs_address == `PCHCM_OFS_CTRL && avs_byteenable[0])
      begin
        next_pci_divide_field = avs_writedata[`PCHCM_CTRL_DIV_MSB:`PCHCM_CTRL_DIV_LSB];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      pci_divide_field <= `PCHCM_CTRL_RESET;
    end
    else
    begin
      ack <= next_ack;
      avs_readdata <= next_readdata;
      pci_divide_field <= next_pci_divide_field;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign cfg_valid = (state == PCHCM_ST_LOCKED);
  assign mode_reserved = factors.reserved;
  assign comms_mult_x2 = factors.comms_x2;
  assign core_pll_mult_x2 = factors.core_x2;
  assign pci_div_x2 = factors.pci_div_x2;
  assign comms_pci_ratio_x2 = ratio.comms_pci_x2;
  assign comms_pci_ratio_bad = ratio.ratio_bad;

endmodule
`default_nettype wire

// File: bench/pchcm_straps.sv
`default_nettype none
module pchcm_straps (
  input wire logic [6:0] mode,
  input wire logic rng,
  output logic [31:0] hard_reset_word,
  output logic [2:0] mode_code_config_pins,
  output logic pci_range_select
);
  timeunit 1ns;
  timeprecision 1ns;
  // unrelated word bits carry junk so a wrong slice shows
  assign hard_reset_word = {mode[6:3], 28'h5a3c96e};
  assign mode_code_config_pins = mode[2:0];
  assign pci_range_select = rng;
endmodule
`default_nettype wire

// File: bench/pchcm_top_sva.sv
`include "pchcm_consts.svh"
`default_nettype none
module pchcm_top_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pci_range_select,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic cfg_valid,
  input wire logic mode_reserved,
  input wire logic [4:0] comms_mult_x2,
  input wire logic [4:0] core_pll_mult_x2,
  input wire logic [4:0] pci_div_x2,
  input wire logic [4:0] comms_pci_ratio_x2,
  input wire logic comms_pci_ratio_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] df;
  logic [3:0] next_df;
  logic [1:0] age;
  logic [1:0] next_age;
  // shadow of the divide field, taken when the write completes
  always_comb
  begin
    next_df = df;
    if (avs_write && !avs_waitrequest && avs_address == 4'h8 && avs_byteenable[0])
      next_df = avs_writedata[3:0];
    next_age = (age == 2'h2) ? age : age + 2'h1;
  end
  always_ff @(posedge clk)
  begin
    df <= rstn ? next_df : `PCHCM_CTRL_RESET;
    age <= rstn ? next_age : 2'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_capture;
    !cfg_valid ##1 cfg_valid;
  endsequence
  a_one_wait: assert property (s_req_wait |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  a_idle_free: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  a_cfg_rise: assert property ($rose(rstn) |-> s_capture)
    else $error("straps not taken at first edge");
  a_cfg_hold: assert property (cfg_valid |=> cfg_valid)
    else $error("valid dropped");
  a_ratio_high: assert property (age == 2'h2 && !pci_range_select |->
    !comms_pci_ratio_bad && comms_pci_ratio_x2 == {1'b0, df} + 5'h01)
    else $error("upper range ratio wrong");
  a_ratio_flag: assert property (age == 2'h2 && pci_range_select |->
    comms_pci_ratio_bad == !(df inside {4'h3, 4'h5, 4'h7, 4'h9, 4'hb}))
    else $error("lower range flag wrong");
  a_fac_hold: assert property (age == 2'h2 |=>
    $stable({comms_mult_x2, core_pll_mult_x2, pci_div_x2, mode_reserved}))
    else $error("factors moved after capture");
  a_rsv_zero: assert property (mode_reserved |->
    {comms_mult_x2, core_pll_mult_x2, pci_div_x2} == 15'h0)
    else $error("reserved mode with factors");
endmodule
`default_nettype wire

// File: bench/tb_pchcm_top.sv
`include "pchcm_consts.svh"
`default_nettype none
module tb_pchcm_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [6:0] mode = 7'h5c;
  logic rng = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  wire [31:0] hard_reset_word;
  wire [31:0] avs_readdata;
  wire [2:0] mode_code_config_pins;
  wire pci_range_select, avs_waitrequest, cfg_valid, mode_reserved, comms_pci_ratio_bad;
  wire [4:0] comms_mult_x2, core_pll_mult_x2, pci_div_x2, comms_pci_ratio_x2;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] q;
  // listed modes plus three reserved ones, as {code, comms, core, pci div}; zero factors mean reserved
  logic [31:0] tbl [17] = '{32'h5c050808, 32'h5d050908, 32'h6805060a, 32'h6905070a,
    32'h6a05080a, 32'h6b05090a, 32'h6c050a0a, 32'h6d04060a, 32'h6e04080a,
    32'h7006070c, 32'h7106080c, 32'h7206090c, 32'h73060a0c, 32'h74060b0c,
    32'h60000000, 32'h62000000, 32'h7f000000};
  always #10 clk = ~clk;
  pchcm_straps u_pchcm_straps (.mode, .rng, .hard_reset_word, .mode_code_config_pins,
    .pci_range_select);
  pchcm_top u_pchcm_top (.clk, .rstn, .hard_reset_word, .mode_code_config_pins,
    .pci_range_select, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .cfg_valid, .mode_reserved,
    .comms_mult_x2, .core_pll_mult_x2, .pci_div_x2, .comms_pci_ratio_x2, .comms_pci_ratio_bad);
  task automatic end_of_test;
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one idle cycle after each access keeps strobes from being driven twice per step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] be);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(q, exp);
  endtask
  task automatic boot(input logic [6:0] m, input logic r);
    mode <= m;
    rng <= r;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [5:0] ratio(input logic r, input logic [3:0] d);
    if (!r)
      return {1'b0, {1'b0, d} + 5'h01};
    case (d)
      4'h3: return 6'h08;
      4'h5: return 6'h0c;
      4'h7: return 6'h10;
      4'h9: return 6'h0a;
      4'hb: return 6'h0c;
      default: return 6'h20;
    endcase
  endfunction
  task automatic t_modes;
    logic [31:0] e;
    foreach (tbl[i])
    begin
      e = tbl[i];
      boot(e[30:24], 1'b0);
      chk({cfg_valid, mode_reserved, comms_mult_x2, core_pll_mult_x2, pci_div_x2},
        {1'b1, e[23:0] == 24'h0, e[20:16], e[12:8], e[4:0]});
      rd(`PCHCM_OFS_FACTORS, {11'h0, e[4:0], 3'h0, e[12:8], 3'h0, e[20:16]});
      rd(`PCHCM_OFS_MODE, {23'h1, e[23:0] == 24'h0, 1'b0, e[30:24]});
    end
  endtask
  task automatic t_ratio(input logic r);
    logic [5:0] e;
    boot(7'h70, r);
    rd(4'h8, {28'h0, `PCHCM_CTRL_RESET});
    rd(`PCHCM_OFS_MODE, {21'h0, r, 10'h270});
    for (int d = 0; d < 16; d++)
    begin
      bus(1'b1, 4'h8, {28'hfffffff, 4'(d)}, 4'h1);
      e = ratio(r, 4'(d));
      rd(4'h8, {28'h0, 4'(d)});
      bus(1'b0, `PCHCM_OFS_RATIO, 32'h0, 4'hf);
      chk(e[5] ? {23'h0, q[8]} : q, e[5] ? 32'h1 : {27'h0, e[4:0]});
      chk(e[5] ? {31'h0, comms_pci_ratio_bad} : {26'h0, comms_pci_ratio_bad, comms_pci_ratio_x2},
        e[5] ? 32'h1 : {27'h0, e[4:0]});
    end
    bus(1'b1, 4'h8, 32'h5, 4'he);
    rd(4'h8, 32'hf);
    rd(4'h2, 32'h0);
  endtask
  task automatic t_late;
    boot(7'h6d, 1'b0);
    mode <= 7'h74;
    repeat (4) @(posedge clk);
    chk({comms_mult_x2, core_pll_mult_x2, pci_div_x2}, {5'h04, 5'h06, 5'h0a});
  endtask
  initial
  begin
    t_modes();
    t_ratio(1'b0);
    t_ratio(1'b1);
    t_late();
    end_of_test();
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end
endmodule
bind pchcm_top pchcm_top_sva u_pchcm_top_sva (.clk, .rstn, .pci_range_select, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .cfg_valid,
  .mode_reserved, .comms_mult_x2, .core_pll_mult_x2, .pci_div_x2, .comms_pci_ratio_x2,
  .comms_pci_ratio_bad);
`default_nettype wire
